// ### hw/sepc_pkg.sv
// Shared constants, types and carriers of the serial EEPROM command logic.
// Assumes one system clock and one serial link clock; no other context.
package sepc_pkg;

  // Array geometry
  localparam int ADDR_W = 13;
  localparam int PAGE_BYTES = 32;

  // Instruction opcodes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;

  // Bit positions within a frame
  localparam logic [4:0] OPC_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h0f;
  localparam logic [2:0] BYTE_LAST = 3'h7;

  // Status register layout
  localparam int ST_PPE = 7;
  localparam int ST_SGH = 3;
  localparam int ST_SGL = 2;
  localparam int ST_WLF = 1;
  localparam int ST_WBF = 0;
  localparam logic [7:0] ST_BUSY_WORD = 8'hff;

  // Values after reset
  localparam logic NV_PPE_RESET = 1'b0;
  localparam logic [1:0] NV_SEG_RESET = 2'h0;
  localparam logic LATCH_RESET = 1'b0;
  localparam logic [7:0] RSP_RESET = 8'h00;
  localparam logic CS_IDLE = 1'b1;

  // Serial frame phases
  typedef enum logic [2:0] {LP_OPC, LP_ADDR, LP_RD, LP_WR, LP_SRIN, LP_IDLE} sepc_phase_t;

  // Commit sequencer states
  typedef enum logic [1:0] {SS_IDLE, SS_WALK, SS_START, SS_WAIT} sepc_sys_t;

  // Request to the memory cell array
  typedef struct packed {
    logic rd;
    logic we;
    logic commit;
    logic nv;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } sepc_mem_t;

endpackage

// ### hw/sepc_ctrl.sv
// Serial command logic of an 8K x 8 serial EEPROM: decode, latch, status, protection.
// Assumes a memory array on i_clk with one-cycle read latency and a busy output.
`timescale 1ns/1ps
module sepc_ctrl
  import sepc_pkg::*;
#(
  parameter int PAGE_BYTES_P = PAGE_BYTES
) (
  // System side
  input wire logic i_clk,
  input wire logic i_rstn,
  // Serial link
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe,
  // Memory cell array
  output sepc_mem_t o_mem,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_mem_busy,
  // Status view
  output logic [7:0] o_status
);

  localparam int PB_W = $clog2(PAGE_BYTES_P);

  function automatic sepc_phase_t opc_phase(input logic [7:0] op);
    case (op)
      OP_STAT_RD: opc_phase = LP_RD;
      OP_STAT_WR: opc_phase = LP_SRIN;
      OP_ARR_RD: opc_phase = LP_ADDR;
      OP_ARR_WR: opc_phase = LP_ADDR;
      default: opc_phase = LP_IDLE;
    endcase
  endfunction

  function automatic logic seg_locked(input logic [1:0] sg, input logic [ADDR_W-1:0] a);
    case (sg)
      2'h0: seg_locked = 1'b0;
      2'h1: seg_locked = a[12] & a[11];
      2'h2: seg_locked = a[12];
      default: seg_locked = 1'b1;
    endcase
  endfunction

  // Link domain declarations
  logic cs_seen, frame_rst_n, take, live, so_go, next_so;
  sepc_phase_t phase, next_phase;
  logic [4:0] cnt, next_cnt;
  logic [15:0] sh, next_sh, addr_in;
  logic [7:0] byte_in, opcode, sr_byte, out_sh, next_out_sh;
  logic byte_end, opc_end, addr_end, armed, next_armed, arm_evt;
  logic req_tgl, req_evt, buf_we;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [PAGE_BYTES_P-1:0] mask, next_mask;
  logic [7:0] pbuf [PAGE_BYTES_P];
  logic [PB_W-1:0] off_next;
  logic [2:0] out_cnt;
  // System domain declarations
  logic cs_s1, cs_s2, cs_q, wp_s1, wp_s2, rq_s1, rq_s2, rq_q, ar_s1, ar_s2;
  logic cs_rise, rq_evt, hw_block, commit, ppe, next_ppe, write_latch_flag, next_wel;
  logic wp_fell, next_wp_fell, rd_pend, next_rd_pend, rd_take;
  logic [1:0] sg, next_sg;
  sepc_sys_t state, next_state;
  logic [PB_W-1:0] idx, next_idx;
  logic [7:0] rsp_word, next_rsp, status_word;
  logic [ADDR_W-1:0] walk_addr;
  sepc_mem_t next_mem;
  // Link clock domain
  // Sticky mark of a deselect since the last reset
  always_ff @(posedge i_cs_n or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_seen <= 1'b0;
    end else begin
      cs_seen <= 1'b1;
    end
  end

  assign frame_rst_n = i_rstn & ~i_cs_n;
  assign take = cs_seen & i_hold_n;
  assign live = take & ~i_cs_n;
  assign byte_in = {sh[6:0], i_si};
  assign addr_in = {sh[14:0], i_si};
  assign byte_end = (cnt[2:0] == BYTE_LAST);
  assign opc_end = (phase == LP_OPC) && (cnt == OPC_LAST);
  assign addr_end = (phase == LP_ADDR) && (cnt == ADDR_LAST);

  always_comb begin
    next_phase = phase;
    next_cnt = cnt + 5'h01;
    next_sh = addr_in;
    case (phase)
      LP_OPC: begin
        if (cnt == OPC_LAST) begin
          next_cnt = '0;
          next_phase = opc_phase(byte_in);
        end
      end
      LP_ADDR: begin
        if (cnt == ADDR_LAST) begin
          next_cnt = '0;
          next_phase = (opcode == OP_ARR_RD) ? LP_RD : LP_WR;
        end
      end
      LP_SRIN: begin
        if (byte_end) begin
          next_phase = LP_IDLE;
        end
      end
      LP_RD, LP_WR: next_phase = phase;
      LP_IDLE: next_cnt = cnt;
      default: next_phase = LP_IDLE;
    endcase
    if (!take) begin
      next_phase = phase;
      next_cnt = cnt;
      next_sh = sh;
    end
  end

  // Frame state, cleared whenever the device is deselected
  always_ff @(posedge i_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase <= LP_OPC;
      cnt <= '0;
      sh <= '0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      sh <= next_sh;
    end
  end

  assign off_next = addr[PB_W-1:0] + PB_W'(1);
  assign buf_we = live && (phase == LP_WR) && byte_end;
  assign arm_evt = (opc_end && (byte_in == OP_LATCH_SET || byte_in == OP_LATCH_CLR))
    || buf_we || (live && (phase == LP_SRIN) && byte_end);
  assign req_evt = live && ((opc_end && byte_in == OP_STAT_RD)
    || (addr_end && opcode == OP_ARR_RD) || ((phase == LP_RD) && byte_end));
  assign next_armed = live ? arm_evt : armed;

  always_comb begin
    next_addr = addr;
    if (live && addr_end) begin
      next_addr = addr_in[ADDR_W-1:0];
    end else if (live && (phase == LP_RD) && byte_end) begin
      next_addr = addr + ADDR_W'(1);
    end else if (buf_we) begin
      next_addr = {addr[ADDR_W-1:PB_W], off_next};
    end
  end

  always_comb begin
    next_mask = mask;
    if (live && opc_end) begin
      next_mask = '0;
    end else if (buf_we) begin
      next_mask[addr[PB_W-1:0]] = 1'b1;
    end
  end

  // Command context, kept past deselect for the commit
  always_ff @(posedge i_sck or negedge i_rstn) begin
    if (!i_rstn) begin
      opcode <= '0;
      addr <= '0;
      mask <= '0;
      armed <= 1'b0;
      sr_byte <= '0;
      req_tgl <= 1'b0;
    end else begin
      opcode <= (live && opc_end) ? byte_in : opcode;
      addr <= next_addr;
      mask <= next_mask;
      armed <= next_armed;
      sr_byte <= (live && (phase == LP_SRIN) && byte_end) ? byte_in : sr_byte;
      req_tgl <= req_tgl ^ req_evt;
    end
  end

  // Page buffer
  always_ff @(posedge i_sck) begin
    if (buf_we) begin
      pbuf[addr[PB_W-1:0]] <= byte_in;
    end
  end

  // Output shifter on the falling edge
  assign so_go = i_hold_n && (phase == LP_RD);

  always_comb begin
    next_so = o_so;
    next_out_sh = out_sh;
    if (so_go) begin
      if (out_cnt == 3'h0) begin
        next_so = rsp_word[7];
        next_out_sh = {rsp_word[6:0], 1'b0};
      end else begin
        next_so = out_sh[7];
        next_out_sh = {out_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge i_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
      out_sh <= '0;
      out_cnt <= '0;
    end else begin
      o_so <= next_so;
      o_so_oe <= (phase == LP_RD);
      out_sh <= next_out_sh;
      out_cnt <= so_go ? out_cnt + 3'h1 : out_cnt;
    end
  end

  // System clock domain

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_s1 <= CS_IDLE;
      cs_s2 <= CS_IDLE;
      cs_q <= CS_IDLE;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      rq_s1 <= 1'b0;
      rq_s2 <= 1'b0;
      rq_q <= 1'b0;
      ar_s1 <= 1'b0;
      ar_s2 <= 1'b0;
    end else begin
      cs_s1 <= i_cs_n;
      cs_s2 <= cs_s1;
      cs_q <= cs_s2;
      wp_s1 <= i_wp_n;
      wp_s2 <= wp_s1;
      rq_s1 <= req_tgl;
      rq_s2 <= rq_s1;
      rq_q <= rq_s2;
      ar_s1 <= armed;
      ar_s2 <= ar_s1;
    end
  end

  assign cs_rise = cs_s2 & ~cs_q;
  assign rq_evt = rq_s2 ^ rq_q;
  assign hw_block = ppe & (~wp_s2 | wp_fell);
  assign next_wp_fell = (cs_s2 & cs_q) ? 1'b0 : (wp_fell | (~wp_s2 & ~cs_s2));
  assign commit = cs_rise & ar_s2 & (state == SS_IDLE);
  assign walk_addr = {addr[ADDR_W-1:PB_W], idx};

  always_comb begin
    status_word = '0;
    status_word[ST_PPE] = ppe;
    status_word[ST_SGH] = sg[1];
    status_word[ST_SGL] = sg[0];
    status_word[ST_WLF] = write_latch_flag;
    status_word[ST_WBF] = 1'b0;
    if (state != SS_IDLE) begin
      status_word = ST_BUSY_WORD;
    end
  end

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_ppe = ppe;
    next_sg = sg;
    next_wel = write_latch_flag;
    next_mem = '0;
    next_mem.addr = o_mem.addr;
    next_mem.wdata = o_mem.wdata;
    case (state)
      SS_IDLE: begin
        if (commit) begin
          case (opcode)
            OP_LATCH_SET: next_wel = 1'b1;
            OP_LATCH_CLR: next_wel = 1'b0;
            OP_STAT_WR: begin
              if (write_latch_flag && !hw_block) begin
                next_ppe = sr_byte[ST_PPE];
                next_sg = {sr_byte[ST_SGH], sr_byte[ST_SGL]};
                next_state = SS_START;
              end
            end
            OP_ARR_WR: begin
              if (write_latch_flag) begin
                next_idx = '0;
                next_state = SS_WALK;
              end
            end
            default: next_state = SS_IDLE;
          endcase
        end
      end
      SS_WALK: begin
        next_mem.we = mask[idx] & ~seg_locked(sg, walk_addr);
        next_mem.addr = walk_addr;
        next_mem.wdata = pbuf[idx];
        next_idx = idx + PB_W'(1);
        if (idx == PB_W'(PAGE_BYTES_P - 1)) begin
          next_state = SS_START;
        end
      end
      SS_START: begin
        next_mem.commit = 1'b1;
        next_mem.nv = (opcode == OP_STAT_WR);
        next_state = SS_WAIT;
      end
      SS_WAIT: begin
        if (!i_mem_busy && !o_mem.commit) begin
          next_wel = 1'b0;
          next_state = SS_IDLE;
        end
      end
      default: next_state = SS_IDLE;
    endcase
    if (rq_evt && state == SS_IDLE && opcode == OP_ARR_RD) begin
      next_mem.rd = 1'b1;
      next_mem.addr = addr;
    end
  end
  always_comb begin
    next_rsp = rsp_word;
    next_rd_pend = 1'b0;
    if (rd_take) begin
      next_rsp = i_mem_rdata;
    end
    if (rq_evt) begin
      if (opcode == OP_STAT_RD) begin
        next_rsp = status_word;
      end else if (state == SS_IDLE) begin
        next_rd_pend = 1'b1;
      end else begin
        next_rsp = ST_BUSY_WORD;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= SS_IDLE;
      idx <= '0;
      ppe <= NV_PPE_RESET;
      sg <= NV_SEG_RESET;
      write_latch_flag <= LATCH_RESET;
      wp_fell <= 1'b0;
      rd_pend <= 1'b0;
      rd_take <= 1'b0;
      rsp_word <= RSP_RESET;
      o_mem <= '0;
      o_status <= '0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      ppe <= next_ppe;
      sg <= next_sg;
      write_latch_flag <= next_wel;
      wp_fell <= next_wp_fell;
      rd_pend <= next_rd_pend;
      rd_take <= rd_pend;
      rsp_word <= next_rsp;
      o_mem <= next_mem;
      o_status <= status_word;
    end
  end

endmodule

// ### sim/sepc_mem_model.sv
// Behavioural memory cell array behind the serial EEPROM command logic.
// Assumes the request carrier of the package and one-cycle read latency.
`timescale 1ns/1ps
module sepc_mem_model
  import sepc_pkg::*;
#(
  parameter int BUSY_CYC = 600
) (
  // System side
  input wire logic i_clk,
  // Requests and answers
  input wire sepc_mem_t i_req,
  output logic [7:0] o_rdata,
  output logic o_busy
);
  logic [7:0] mem [0:8191];
  int cnt = 0;
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = i[7:0];
    end
  end
  // Read data is only valid the cycle after a read pulse
  always @(posedge i_clk) begin
    if (i_req.rd) begin
      o_rdata <= o_busy ? 8'hff : mem[i_req.addr];
    end else begin
      o_rdata <= ~o_rdata;
    end
    if (i_req.we) begin
      mem[i_req.addr] <= i_req.wdata;
    end
    if (i_req.commit) begin
      cnt <= BUSY_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign o_busy = (cnt != 0);
endmodule

// ### sim/sepc_ctrl_properties.sv
// Property checker of the serial EEPROM command logic.
// Assumes only the ports of the controller; bound below.
`timescale 1ns/1ps
module sepc_ctrl_properties
  import sepc_pkg::*;
#(
  parameter int PAGE_BYTES_P = PAGE_BYTES
) (
  // System side
  input wire logic i_clk,
  input wire logic i_rstn,
  // Serial link
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  // Memory and status
  input wire sepc_mem_t o_mem,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_mem_busy,
  input wire logic [7:0] o_status
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Last idle view of the protection bits; status reads all ones while busy
  logic [1:0] seg;
  logic ppe_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seg <= NV_SEG_RESET;
      ppe_q <= NV_PPE_RESET;
    end else if (!o_status[ST_WBF]) begin
      seg <= o_status[ST_SGH:ST_SGL];
      ppe_q <= o_status[ST_PPE];
    end
  end
  wire logic lock = seg == 2'h3 || (seg == 2'h2 && o_mem.addr[12])
    || (seg == 2'h1 && o_mem.addr[12:11] == 2'h3);
  chk_oe_desel: assert property (i_cs_n && $past(i_cs_n) |-> !o_so_oe)
    else $error("output enabled while deselected");
  chk_so_steady: assert property (
    i_sck && $past(i_sck) && !i_cs_n && !$past(i_cs_n) |-> $stable(o_so))
    else $error("serial output moved while clock high");
  chk_busy_word: assert property (
    $rose(i_mem_busy) |-> ##[1:3] o_status == ST_BUSY_WORD)
    else $error("status not all ones during write");
  chk_busy_done: assert property (
    $fell(i_mem_busy) |-> ##[1:4] (!o_status[ST_WBF] && !o_status[ST_WLF]))
    else $error("busy or latch flag left after write");
  chk_free_bits: assert property (!o_status[ST_WBF] |-> o_status[6:4] == 3'h0)
    else $error("unused status bits not zero");
  chk_lock_write: assert property (o_mem.we |-> !lock)
    else $error("write into locked segment");
  chk_read_sel: assert property (o_mem.rd |-> !i_cs_n)
    else $error("array read while deselected");
  chk_pin_guard: assert property (
    o_mem.commit && o_mem.nv && !i_wp_n && !$past(i_wp_n, 8) |-> !ppe_q)
    else $error("status write under pin protection");
endmodule
bind sepc_ctrl sepc_ctrl_properties #(.PAGE_BYTES_P(PAGE_BYTES_P)) chk_u (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
  .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_mem(o_mem),
  .i_mem_rdata(i_mem_rdata), .i_mem_busy(i_mem_busy), .o_status(o_status)
);

// ### sim/tb_top.sv
// Self-checking bench of the serial EEPROM command logic.
// Assumes the array model and the bound property checker.
`timescale 1ns/1ps
module tb_top;
  import sepc_pkg::*;
  logic clk, rstn, sck, cs_n, si, hold_n, wp_n, so, so_oe, busy;
  logic [7:0] rdata, status, rx;
  sepc_mem_t mreq;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  sepc_ctrl dut_u (
    .i_clk(clk), .i_rstn(rstn), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .o_mem(mreq),
    .i_mem_rdata(rdata), .i_mem_busy(busy), .o_status(status)
  );
  sepc_mem_model mem_u (.i_clk(clk), .i_req(mreq), .o_rdata(rdata), .o_busy(busy));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pause();
    #20 hold_n = 1'b0;
    repeat (3) begin
      #40 sck = 1'b1;
      si = ~si;
      #40 sck = 1'b0;
    end
    #40 hold_n = 1'b1;
  endtask
  task automatic xb(input logic [7:0] tx, input int pz = 8, input int nb = 8);
    for (int i = 7; i > 7 - nb; i--) begin
      if (i == pz) pause();
      si = tx[i];
      #40 sck = 1'b1;
      rx[i] = so;
      #40 sck = 1'b0;
    end
  endtask
  task automatic sel();
    @(posedge clk);
    #1 cs_n = 1'b0;
    #40;
  endtask
  task automatic desel();
    #40 cs_n = 1'b1;
    repeat (50) @(posedge clk);
    #1;
  endtask
  task automatic cmd8(input logic [7:0] op);
    sel();
    xb(op);
    desel();
  endtask
  task automatic status_read_cmd(input logic [7:0] exp, input logic [7:0] msk = 8'hff);
    sel();
    xb(OP_STAT_RD);
    xb(8'h00);
    desel();
    chk("status", rx & msk, exp);
  endtask
  task automatic wait_done();
    repeat (20) @(posedge clk);
    for (int n = 0; n < 2000 && busy; n++) @(posedge clk);
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic swr(input logic [7:0] v);
    cmd8(OP_LATCH_SET);
    sel();
    xb(OP_STAT_WR);
    xb(v);
    desel();
    wait_done();
  endtask
  task automatic aw(input logic [15:0] a, input logic [7:0] d);
    cmd8(OP_LATCH_SET);
    sel();
    xb(OP_ARR_WR);
    xb(a[15:8]);
    xb(a[7:0]);
    xb(d);
    xb(8'h88, 8, 5);
    desel();
    wait_done();
  endtask
  task automatic t_basic();
    chk("oe", {7'h0, so_oe}, 8'h00);
    xb(OP_LATCH_SET);
    desel();
    status_read_cmd(8'h00);
    cmd8(OP_LATCH_SET);
    status_read_cmd(8'h02);
    cmd8(OP_LATCH_CLR);
    status_read_cmd(8'h00);
    sel();
    xb(OP_LATCH_SET);
    xb(8'h00);
    desel();
    status_read_cmd(8'h00);
    sel();
    xb(8'ha5);
    xb(8'h00);
    chk("oe", {7'h0, so_oe}, 8'h00);
    desel();
    $display("done basic");
  endtask
  task automatic t_page();
    cmd8(OP_LATCH_SET);
    sel();
    xb(OP_ARR_WR);
    xb(8'he0);
    xb(8'h1e);
    xb(8'ha1);
    xb(8'hb2);
    xb(8'hc3, 3);
    desel();
    status_read_cmd(8'hff);
    wait_done();
    status_read_cmd(8'h00);
    chk("m1e", mem_u.mem[30], 8'ha1);
    chk("m1f", mem_u.mem[31], 8'hb2);
    chk("m00", mem_u.mem[0], 8'hc3);
    sel();
    xb(OP_ARR_RD);
    xb(8'h00, 4);
    xb(8'h1e);
    xb(8'h00);
    chk("rd0", rx, 8'ha1);
    xb(8'h00);
    chk("rd1", rx, 8'hb2);
    xb(8'h00);
    chk("rd2", rx, 8'h20);
    desel();
    aw(16'h0040, 8'h77);
    chk("m40", mem_u.mem[64], 8'h40);
    status_read_cmd(8'h02);
    cmd8(OP_LATCH_CLR);
    $display("done page");
  endtask
  task automatic t_lock();
    logic [7:0] ev [3];
    logic [15:0] a;
    ev = '{8'h00, 8'h00, 8'h00};
    for (int s = 0; s < 4; s++) begin
      swr(8'(s << 2));
      status_read_cmd(8'(s << 2));
      for (int k = 1; k < 4; k++) begin
        a = 16'(k) << 11;
        cmd8(OP_LATCH_SET);
        sel();
        xb(OP_ARR_WR);
        xb(a[15:8]);
        xb(a[7:0]);
        xb(8'h10 + 8'(s));
        desel();
        wait_done();
        if (!(s == 3 || (s == 2 && k > 1) || (s == 1 && k == 3))) ev[k-1] = 8'h10 + 8'(s);
        chk("lock", mem_u.mem[a[12:0]], ev[k-1]);
      end
    end
    swr(8'h00);
    $display("done lock");
  endtask
  task automatic t_protect();
    swr(8'h80);
    status_read_cmd(8'h80);
    wp_n = 1'b0;
    swr(8'h00);
    status_read_cmd(8'h80, 8'h8c);
    wp_n = 1'b1;
    cmd8(OP_LATCH_SET);
    sel();
    xb(OP_STAT_WR);
    wp_n = 1'b0;
    xb(8'h00);
    wp_n = 1'b1;
    desel();
    wait_done();
    status_read_cmd(8'h80, 8'h8c);
    swr(8'h00);
    wp_n = 1'b0;
    swr(8'h04);
    status_read_cmd(8'h04, 8'h8c);
    wp_n = 1'b1;
    $display("done protect");
  endtask
  initial begin
    rstn = 1'b0;
    cs_n = 1'b0;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    t_basic();
    t_page();
    t_lock();
    t_protect();
    tally_and_finish();
  end
endmodule
